// file: hw/dtwi_pkg.sv
// package: register map, field positions and timing constants of the dual timer block
package dtwi_pkg;
	// word indices of the nibble registers (byte address = 4 * index)
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] IDX_IRQ_REQUEST = 8'h01;
	localparam logic [7:0] IDX_T0_MODE = 8'h02;
	localparam logic [7:0] IDX_T1_CONTROL = 8'h03;
	localparam logic [7:0] IDX_AUX_ENABLE = 8'h0a;
	localparam logic [7:0] IDX_AUX_REQUEST = 8'h0b;
	localparam logic [7:0] IDX_PIN_FUNC = 8'h15;
	localparam logic [7:0] IDX_T0_LOW = 8'h24;
	localparam logic [7:0] IDX_T0_HIGH = 8'h25;
	localparam logic [7:0] IDX_T1_LOW = 8'h26;
	localparam logic [7:0] IDX_T1_HIGH = 8'h27;
	localparam logic [7:0] IDX_VECTOR = 8'h28;
	localparam logic [7:0] IDX_ACK = 8'h29;
	// field positions
	localparam int BIT_ADC = 3;
	localparam int BIT_T0 = 2;
	localparam int BIT_T1 = 1;
	localparam int BIT_GROUP = 0;
	localparam int BIT_AUX_PORT = 2;
	localparam int BIT_AUX_CMP = 3;
	localparam int BIT_EDGE_SEL = 3;
	localparam int BIT_T1_RUN = 3;
	localparam logic [1:0] PIN5_EVENT = 2'b10;
	localparam logic [2:0] PRESC_UNDIV = 3'h7;
	localparam logic [3:0] RESET_NIB = 4'h0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	// system clock is the oscillator divided by four
	localparam int OSC_PER_SYS = 4;
	// instruction delay before service once an enabled request is pending
	localparam logic [1:0] SERVICE_DELAY = 2'h2;
	localparam logic [2:0] VEC_NONE = 3'h0;
	localparam logic [2:0] VEC_ADC = 3'h1;
	localparam logic [2:0] VEC_T0 = 3'h2;
	localparam logic [2:0] VEC_T1 = 3'h3;
	localparam logic [2:0] VEC_GROUP = 3'h4;

	typedef struct packed {
		logic [3:0] reload_low;
		logic [7:0] reload;
		logic [7:0] count;
		logic [10:0] presc;
		logic [2:0] sel;
		logic flag;
	} dtwi_timer_t;

	typedef struct packed {
		dtwi_timer_t t0;
		dtwi_timer_t t1;
		logic edge_sel;
		logic t1_run;
		logic [1:0] pin5_func;
		logic [3:0] ie;
		logic [3:0] irq;
		logic [3:0] aux_ie;
		logic [3:0] aux_irq;
		logic [3:0] count_hold;
		logic ev_s1;
		logic ev_s2;
		logic ev_s3;
		logic cmp_prev;
		logic [3:0] port_prev;
		logic [1:0] wait_cnt;
		logic armed;
		logic [2:0] vector;
		logic take;
		logic dph;
		logic dp_write;
		logic [7:0] dp_idx;
		logic [31:0] rdata;
	} dtwi_state_t;
endpackage : dtwi_pkg

// file: hw/dtwi_top.sv
// dual 8-bit auto-reload timers with interrupt flag and vector logic, AHB-Lite slave
// Summary of operation
// - two 8-bit reloads and counters in nibbles
// - reload on high write and on wrap
// - low nibble held, committed on high write
// - 3-bit prescaler select, 2^11 down to 2^0
// - timer1 system clock, timer0 clock or pin
// - event pin synchronised once per cycle
// - edge select bit3: 0 rise, 1 fall
// - timer1 counts when run or select 111
// - run bit command write, status read, stopped
// - wrap sets that timer's request flag
// - main flags: adc3 t0 2 t1 1 group0
// - reset clears all enables and requests
// - request and enable give vector service
// - entering service clears every main enable flag
// - service two instructions after enabling, cancellable
// - adc done sets flag; enabled adc, t0, t1 requests wake
// - digital input falling edge sets port flag
// - port and group enables set group flag
// - comparator change sets flag, maybe group
// - aux registers: port bit2, comparator bit3
// - system clock is oscillator over four
`timescale 1ns/1ps
module dtwi_top
	import dtwi_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [2:0] HBURST,
	input wire logic [3:0] HPROT,
	input wire logic HMASTLOCK,
	input wire logic HREADY,
	input wire logic [31:0] HWDATA,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic EXT_EVENT_INPUT,
	input wire logic ADC_DONE,
	input wire logic CMP_OUT,
	input wire logic [3:0] PORT_IN,
	input wire logic [3:0] PORT_DIGITAL,
	input wire logic INSTR_DONE,
	output logic IRQ_TAKE,
	output logic [2:0] IRQ_VECTOR,
	output logic WAKE
);
	dtwi_state_t s;
	dtwi_state_t next_s;

	// prescaler tap: 1 on the clock where the divided tick fires
	function automatic logic presc_tick(input logic [10:0] cnt, input logic [2:0] sel);
		logic [10:0] mask;
		mask = 11'h000;
		case (sel)
			3'h0: mask = 11'h7ff;
			3'h1: mask = 11'h1ff;
			3'h2: mask = 11'h07f;
			3'h3: mask = 11'h01f;
			3'h4: mask = 11'h007;
			3'h5: mask = 11'h003;
			3'h6: mask = 11'h001;
			default: mask = 11'h000;
		endcase
		return (cnt & mask) == mask;
	endfunction : presc_tick

	// one timer step: prescaler, count, wrap reload
	function automatic dtwi_timer_t timer_step(input dtwi_timer_t t, input logic inc);
		dtwi_timer_t r;
		r = t;
		if (inc) begin
			r.presc = t.presc + 11'h001;
			if (presc_tick(t.presc, t.sel)) begin
				r.presc = 11'h000;
				if (t.count == COUNT_MAX) begin
					r.count = t.reload;
					r.flag = 1'b1;
				end else begin
					r.count = t.count + 8'h01;
				end
			end
		end
		return r;
	endfunction : timer_step

	logic ap_valid;
	logic ev_tick;
	logic ev_rise;
	logic ev_fall;
	logic [3:0] wdat;
	logic [3:0] pend;
	logic [3:0] port_fall;
	logic cmp_chg;
	logic t0_inc;
	logic t1_inc;

	assign ap_valid = HSEL && HREADY && HTRANS[1];
	assign wdat = HWDATA[3:0];
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign HRDATA = s.rdata;
	assign IRQ_TAKE = s.take;
	assign IRQ_VECTOR = s.vector;
	assign pend = s.irq & s.ie;
	assign WAKE = pend[BIT_ADC] | pend[BIT_T0] | pend[BIT_T1];

	always_comb begin
		next_s = s;
		next_s.take = 1'b0;
		// ev_s1 feeds only ev_s2; edges come from later stages
		next_s.ev_s1 = EXT_EVENT_INPUT;
		next_s.ev_s2 = s.ev_s1;
		next_s.ev_s3 = s.ev_s2;
		ev_rise = s.ev_s2 & ~s.ev_s3;
		ev_fall = ~s.ev_s2 & s.ev_s3;
		ev_tick = s.edge_sel ? ev_fall : ev_rise;
		// timer0 source from the pin function select
		t0_inc = (s.pin5_func == PIN5_EVENT) ? ev_tick : 1'b1;
		t1_inc = s.t1_run | (s.t1.sel == PRESC_UNDIV);
		next_s.t0 = timer_step(s.t0, t0_inc);
		next_s.t1 = timer_step(s.t1, t1_inc);

		port_fall = s.port_prev & ~PORT_IN & PORT_DIGITAL;
		next_s.port_prev = PORT_IN;
		cmp_chg = CMP_OUT ^ s.cmp_prev;
		next_s.cmp_prev = CMP_OUT;

		// software accesses: clear by writing zero, set events win
		if (s.dp_write) begin
			if (s.dp_idx == IDX_IRQ_ENABLE) begin
				next_s.ie = wdat;
			end else if (s.dp_idx == IDX_IRQ_REQUEST) begin
				next_s.irq = s.irq & wdat;
			end else if (s.dp_idx == IDX_T0_MODE) begin
				next_s.edge_sel = wdat[BIT_EDGE_SEL];
				next_s.t0.sel = wdat[2:0];
			end else if (s.dp_idx == IDX_T1_CONTROL) begin
				next_s.t1_run = wdat[BIT_T1_RUN];
				next_s.t1.sel = wdat[2:0];
			end else if (s.dp_idx == IDX_AUX_ENABLE) begin
				next_s.aux_ie = {wdat[3:2], 2'b00};
			end else if (s.dp_idx == IDX_AUX_REQUEST) begin
				next_s.aux_irq = s.aux_irq & {wdat[3:2], 2'b00};
			end else if (s.dp_idx == IDX_PIN_FUNC) begin
				next_s.pin5_func = wdat[3:2];
			end else if (s.dp_idx == IDX_T0_LOW) begin
				next_s.t0.reload_low = wdat;
			end else if (s.dp_idx == IDX_T0_HIGH) begin
				next_s.t0.reload = {wdat, s.t0.reload_low};
				next_s.t0.count = {wdat, s.t0.reload_low};
				next_s.t0.presc = 11'h000;
			end else if (s.dp_idx == IDX_T1_LOW) begin
				next_s.t1.reload_low = wdat;
			end else if (s.dp_idx == IDX_T1_HIGH) begin
				next_s.t1.reload = {wdat, s.t1.reload_low};
				next_s.t1.count = {wdat, s.t1.reload_low};
				next_s.t1.presc = 11'h000;
			end
		end

		// flag-setting events after the clears so a set wins
		if (next_s.t0.flag) begin
			next_s.irq[BIT_T0] = 1'b1;
		end
		if (next_s.t1.flag) begin
			next_s.irq[BIT_T1] = 1'b1;
		end
		next_s.t0.flag = 1'b0;
		next_s.t1.flag = 1'b0;
		if (ADC_DONE) begin
			next_s.irq[BIT_ADC] = 1'b1;
		end
		if (|port_fall) begin
			next_s.aux_irq[BIT_AUX_PORT] = 1'b1;
			if (s.aux_ie[BIT_AUX_PORT] && s.ie[BIT_GROUP]) begin
				next_s.irq[BIT_GROUP] = 1'b1;
			end
		end
		if (cmp_chg) begin
			next_s.aux_irq[BIT_AUX_CMP] = 1'b1;
			if (s.aux_ie[BIT_AUX_CMP] && s.ie[BIT_GROUP]) begin
				next_s.irq[BIT_GROUP] = 1'b1;
			end
		end

		// service delay: two retired instructions, cancelled if pending drops
		if (!(|(next_s.irq & next_s.ie))) begin
			next_s.armed = 1'b0;
			next_s.wait_cnt = 2'h0;
		end else if (!s.armed) begin
			next_s.armed = 1'b1;
			next_s.wait_cnt = 2'h0;
		end else if (INSTR_DONE) begin
			if (s.wait_cnt == SERVICE_DELAY - 2'h1) begin
				next_s.take = 1'b1;
				next_s.ie = 4'h0;
				next_s.armed = 1'b0;
				next_s.wait_cnt = 2'h0;
				if (pend[BIT_ADC]) begin
					next_s.vector = VEC_ADC;
				end else if (pend[BIT_T0]) begin
					next_s.vector = VEC_T0;
				end else if (pend[BIT_T1]) begin
					next_s.vector = VEC_T1;
				end else begin
					next_s.vector = VEC_GROUP;
				end
			end else begin
				next_s.wait_cnt = s.wait_cnt + 2'h1;
			end
		end

		// bus address phase, read data prepared for the data phase
		next_s.dp_write = ap_valid && HWRITE;
		next_s.dp_idx = HADDR[9:2];
		if (ap_valid && !HWRITE) begin
			next_s.rdata = 32'h0000_0000;
			if (HADDR[31:10] != 22'h000000) begin
				next_s.rdata = 32'h0000_0000;
			end else if (HADDR[9:2] == IDX_IRQ_ENABLE) begin
				next_s.rdata[3:0] = s.ie;
			end else if (HADDR[9:2] == IDX_IRQ_REQUEST) begin
				next_s.rdata[3:0] = s.irq;
			end else if (HADDR[9:2] == IDX_T0_MODE) begin
				next_s.rdata[3:0] = {s.edge_sel, s.t0.sel};
			end else if (HADDR[9:2] == IDX_T1_CONTROL) begin
				next_s.rdata[3:0] = {s.t1_run, s.t1.sel};
			end else if (HADDR[9:2] == IDX_AUX_ENABLE) begin
				next_s.rdata[3:0] = s.aux_ie;
			end else if (HADDR[9:2] == IDX_AUX_REQUEST) begin
				next_s.rdata[3:0] = s.aux_irq;
			end else if (HADDR[9:2] == IDX_PIN_FUNC) begin
				next_s.rdata[3:0] = {s.pin5_func, 2'b00};
			end else if (HADDR[9:2] == IDX_T0_HIGH) begin
				next_s.rdata[3:0] = s.t0.count[7:4];
				next_s.count_hold = s.t0.count[3:0];
			end else if (HADDR[9:2] == IDX_T0_LOW) begin
				next_s.rdata[3:0] = s.count_hold;
			end else if (HADDR[9:2] == IDX_T1_HIGH) begin
				next_s.rdata[3:0] = s.t1.count[7:4];
				next_s.count_hold = s.t1.count[3:0];
			end else if (HADDR[9:2] == IDX_T1_LOW) begin
				next_s.rdata[3:0] = s.count_hold;
			end else if (HADDR[9:2] == IDX_VECTOR) begin
				next_s.rdata[2:0] = s.vector;
			end
		end
	end

	// CLK is the system clock, the oscillator over four
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : dtwi_top

// file: sim/dtwi_top_assertions.sv
// checker: bus and interrupt-service timing at the dual timer block's ports
`timescale 1ns/1ps
module dtwi_top_checker
	import dtwi_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic IRQ_TAKE,
	input wire logic [2:0] IRQ_VECTOR,
	input wire logic WAKE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence rd_unmapped;
		HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == 32'h24;
	endsequence
	sequence take_once;
		IRQ_TAKE ##1 !IRQ_TAKE;
	endsequence
	ready_high_a: assert property (HREADYOUT)
		else $error("slave inserted a wait state");
	resp_okay_a: assert property (!HRESP)
		else $error("slave answered with an error");
	upper_zero_a: assert property (HRDATA[31:4] == 28'h0)
		else $error("read data above the nibble not zero");
	unmapped_zero_a: assert property (rd_unmapped |=> HRDATA == 32'h0)
		else $error("unmapped read returned nonzero");
	take_single_a: assert property (IRQ_TAKE |-> take_once)
		else $error("service entry longer than one cycle");
	vector_valid_a: assert property (IRQ_TAKE |-> IRQ_VECTOR inside {[3'h1:3'h4]})
		else $error("service entered without a source vector");
	vector_hold_a: assert property (!$stable(IRQ_VECTOR) |-> IRQ_TAKE)
		else $error("vector changed outside service entry");
	take_clears_a: assert property (IRQ_TAKE |=> !WAKE)
		else $error("enables survived service entry");
endmodule : dtwi_top_checker
bind dtwi_top dtwi_top_checker i_chk(.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ_TAKE(IRQ_TAKE),
	.IRQ_VECTOR(IRQ_VECTOR), .WAKE(WAKE));

// file: sim/dtwi_core_model.sv
// core model: instruction retire pulses and event pin toggling
`timescale 1ns/1ps
module dtwi_core_model #(
	parameter int GAP = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ev_go,
	input wire logic [7:0] ev_n,
	output logic instr_done,
	output logic ext_event
);
	int cnt;
	logic [7:0] left;
	logic hold;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			instr_done <= 1'b0;
			left <= 8'h0;
			hold <= 1'b0;
			ext_event <= 1'b0;
		end else begin
			cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
			instr_done <= (cnt == GAP - 1);
			if (ev_go) begin
				left <= ev_n;
			end else if (left != 8'h0) begin
				// each level held two system cycles
				hold <= ~hold;
				if (hold) begin
					ext_event <= ~ext_event;
					left <= left - 8'h1;
				end
			end
		end
	end
endmodule : dtwi_core_model

// file: sim/tb.sv
// testbench: registers, timers, event counting and interrupt service
`timescale 1ns/1ps
module tb;
	import dtwi_pkg::*;
	logic CLK = 1'b0, RSTN = 1'b0, HWRITE = 1'b0, ADC_DONE = 1'b0, CMP_OUT = 1'b0, ev_go = 1'b0;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, q, seed = 32'hbea8;
	logic [1:0] HTRANS = 2'h0;
	logic [3:0] PORT_IN = 4'hf, PORT_DIGITAL = 4'h1;
	logic [7:0] ev_n = 8'h00;
	logic HREADYOUT, HRESP, EXT_EVENT_INPUT, INSTR_DONE, IRQ_TAKE, WAKE;
	logic [2:0] IRQ_VECTOR;
	int fails = 0, comparisons = 0, takes = 0;
	dtwi_top i_dut(.CLK(CLK), .RSTN(RSTN), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(3'h2), .HBURST(3'h0), .HPROT(4'h0), .HMASTLOCK(1'b0),
		.HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .EXT_EVENT_INPUT(EXT_EVENT_INPUT), .ADC_DONE(ADC_DONE),
		.CMP_OUT(CMP_OUT), .PORT_IN(PORT_IN), .PORT_DIGITAL(PORT_DIGITAL),
		.INSTR_DONE(INSTR_DONE), .IRQ_TAKE(IRQ_TAKE), .IRQ_VECTOR(IRQ_VECTOR), .WAKE(WAKE));
	dtwi_core_model i_core(.clk(CLK), .rst_n(RSTN), .ev_go(ev_go), .ev_n(ev_n),
		.instr_done(INSTR_DONE), .ext_event(EXT_EVENT_INPUT));
	initial forever #50 CLK = ~CLK;
	always @(posedge CLK) if (IRQ_TAKE === 1'b1) takes <= takes + 1;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	function automatic int div_of(input logic [2:0] s);
		return (s < 3'h4) ? (1 << (11 - 2 * s)) : (1 << (7 - s));
	endfunction : div_of
	task finish_test;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test
	task chk(input string n, input logic [31:0] e, s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [3:0] d);
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= {28'h0, d};
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		q = HRDATA;
	endtask : bus
	task rc(input logic [7:0] a, input logic [3:0] e);
		bus(1'b0, a, 4'h0);
		chk($sformatf("reg %h", a), {28'h0, e}, q);
	endtask : rc
	task tk(input logic [2:0] v, input int n);
		for (int i = 0; i < 300 && takes < n; i++) @(posedge CLK);
		chk("takes", n, takes);
		chk("vector", {29'h0, v}, {29'h0, IRQ_VECTOR});
	endtask : tk
	initial begin
		repeat (20000) @(posedge CLK);
		fails++;
		finish_test;
	end
	initial begin
		repeat (12) @(posedge CLK);
		RSTN <= 1'b1;
		@(posedge CLK);
		rc(8'h00, 4'h0);
		rc(8'h04, 4'h0);
		rc(8'h0c, 4'h0);
		repeat (4) begin
			seed = xs(seed);
			bus(1'b1, 8'h00, seed[3:0]);
			rc(8'h00, seed[3:0]);
			bus(1'b1, 8'h28, seed[7:4]);
			rc(8'h28, seed[7:4] & 4'hc);
			bus(1'b1, 8'h24, seed[11:8]);
			rc(8'h24, 4'h0);
		end
		bus(1'b1, 8'h00, 4'h0);
		bus(1'b1, 8'h28, 4'h0);
		for (int s = 3; s < 8; s++) begin
			bus(1'b1, 8'h98, 4'he);
			bus(1'b1, 8'h9c, 4'hf);
			bus(1'b1, 8'h04, 4'h0);
			bus(1'b1, 8'h0c, {s != 7, s[2:0]});
			if (div_of(s[2:0]) >= 8) rc(8'h04, 4'h0);
			repeat (2 * div_of(s[2:0]) + 4) @(posedge CLK);
			rc(8'h04, 4'h2);
			bus(1'b1, 8'h0c, 4'h0);
			rc(8'h9c, 4'hf);
		end
		bus(1'b1, 8'h0c, 4'h6);
		bus(1'b1, 8'h04, 4'h0);
		repeat (20) @(posedge CLK);
		rc(8'h04, 4'h0);
		rc(8'h0c, 4'h6);
		bus(1'b1, 8'h0c, 4'he);
		rc(8'h0c, 4'he);
		bus(1'b1, 8'h0c, 4'h0);
		bus(1'b1, 8'h54, 4'h8);
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, 8'h08, k ? 4'hf : 4'h7);
			bus(1'b1, 8'h90, 4'h0);
			bus(1'b1, 8'h94, 4'h0);
			ev_n <= k ? 8'h3 : 8'h5;
			ev_go <= 1'b1;
			@(posedge CLK);
			ev_go <= 1'b0;
			repeat (40) @(posedge CLK);
			rc(8'h94, 4'h0);
			rc(8'h90, k ? 4'h2 : 4'h3);
		end
		bus(1'b1, 8'h04, 4'h0);
		ADC_DONE <= 1'b1;
		@(posedge CLK);
		ADC_DONE <= 1'b0;
		bus(1'b1, 8'h98, 4'hf);
		bus(1'b1, 8'h9c, 4'hf);
		bus(1'b1, 8'h0c, 4'h7);
		bus(1'b1, 8'h0c, 4'h0);
		rc(8'h04, 4'ha);
		bus(1'b1, 8'h00, 4'hf);
		@(posedge CLK);
		chk("wake", 32'h1, {31'h0, WAKE});
		tk(VEC_ADC, 1);
		rc(8'h00, 4'h0);
		rc(8'h04, 4'ha);
		bus(1'b1, 8'h00, 4'h8);
		bus(1'b1, 8'h00, 4'h0);
		repeat (40) @(posedge CLK);
		chk("cancelled", 1, takes);
		bus(1'b1, 8'h04, 4'h2);
		bus(1'b1, 8'h00, 4'h2);
		tk(VEC_T1, 2);
		bus(1'b1, 8'h04, 4'h0);
		bus(1'b1, 8'h2c, 4'h0);
		bus(1'b1, 8'h28, 4'h4);
		bus(1'b1, 8'h00, 4'h1);
		PORT_IN <= 4'hd;
		repeat (4) @(posedge CLK);
		rc(8'h2c, 4'h0);
		PORT_IN <= 4'hc;
		tk(VEC_GROUP, 3);
		rc(8'h2c, 4'h4);
		CMP_OUT <= 1'b1;
		repeat (4) @(posedge CLK);
		rc(8'h2c, 4'hc);
		// timer0 back on the system clock, wrap lands on the same edge as the clear
		bus(1'b1, 8'h54, 4'h0);
		bus(1'b1, 8'h90, 4'he);
		bus(1'b1, 8'h94, 4'hf);
		bus(1'b1, 8'h04, 4'h0);
		rc(8'h04, 4'h4);
		bus(1'b1, 8'h00, 4'h4);
		@(posedge CLK);
		chk("wake", 32'h1, {31'h0, WAKE});
		tk(VEC_T0, 4);
		finish_test;
	end
endmodule : tb
